/* adcp_pkg.sv */
// Shared constants and types for the converter register port over I2C
package adcp_pkg;

    localparam int CLK_PERIOD_NS = 8;
    localparam int SCL_PERIOD_NS = 10000;
    localparam int QTR_CYCLES    = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);

    localparam logic [6:0] BASE_ADDR = 7'h48;

    localparam logic [1:0] PTR_CONV = 2'h0;
    localparam logic [1:0] PTR_CFG  = 2'h1;
    localparam logic [1:0] PTR_LO   = 2'h2;
    localparam logic [1:0] PTR_HI   = 2'h3;

    localparam logic [15:0] CFG_RESET = 16'h0000;
    localparam logic [15:0] LO_RESET  = 16'h8000;
    localparam logic [15:0] HI_RESET  = 16'h7FFF;

    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

    localparam logic [2:0] IDX_ADDR = 3'h0;
    localparam logic [2:0] IDX_PTR  = 3'h1;
    localparam logic [2:0] IDX_HI   = 3'h2;
    localparam logic [2:0] IDX_LO   = 3'h3;
    localparam logic [2:0] IDX_OVER = 3'h4;

    typedef enum logic [1:0] {
        OP_WRITE,
        OP_POINT,
        OP_READ
    } adcp_op_type;

endpackage

/* adcp_bus_if.sv */
// Two-wire open-drain bus joining controller and target
`timescale 1ns/1ps
`default_nettype none
interface adcp_bus_if;
    logic host_scl_out;
    logic host_scl_oe_n;
    logic host_sda_out;
    logic host_sda_oe_n;
    logic dev_sda_out;
    logic dev_sda_oe_n;
    logic scl;
    logic sda;

    // Wired-AND of open-drain drivers with pull-ups
    assign scl = host_scl_oe_n | host_scl_out;
    assign sda = (host_sda_oe_n | host_sda_out)
               & (dev_sda_oe_n | dev_sda_out);

    modport dev  (input scl, input sda,
                  output dev_sda_out, output dev_sda_oe_n);
    modport host (input sda,
                  output host_scl_out, output host_scl_oe_n,
                  output host_sda_out, output host_sda_oe_n);
endinterface
`default_nettype wire

/* adcp_device.sv */
// Target end: I2C register port with pointer and four 16-bit registers
`timescale 1ns/1ps
`default_nettype none
module adcp_device #(
    parameter logic [6:0] BASE = adcp_pkg::BASE_ADDR // address with strap 0
) (
    input  wire logic        clk,       // system clock
    input  wire logic        rst,       // synchronous reset
    input  wire logic        ce,        // clock enable
    adcp_bus_if.dev          bus,       // two-wire bus
    input  wire logic [1:0]  addr_sel,  // address strap
    input  wire logic [15:0] conv_word, // conversion result
    output logic      [15:0] cfg_word,  // configuration register
    output logic      [15:0] lo_word,   // low threshold register
    output logic      [15:0] hi_word,   // high threshold register
    output logic             wr_pulse,  // register written
    output logic      [1:0]  wr_index   // which register
);
    import adcp_pkg::*;

    typedef enum {
        ST_IDLE,
        ST_RX,
        ST_ACK,
        ST_TX,
        ST_MACK,
        ST_SKIP
    } adcp_dstate_type;

    adcp_dstate_type st;
    logic [1:0]  scl_sy;
    logic [1:0]  sda_sy;
    logic [1:0]  sel_sy0;
    logic [1:0]  sel_sy1;
    logic        scl_d;
    logic        sda_d;
    logic        scl_rise;
    logic        scl_fall;
    logic        start_seen;
    logic        stop_seen;
    logic [6:0]  my_addr;
    logic [3:0]  bit_cnt;
    logic [7:0]  shreg;
    logic [7:0]  rx_byte;
    logic [2:0]  byte_idx;
    logic        rd_mode;
    logic        ack_drv;
    logic [1:0]  ptr;
    logic [7:0]  hold_hi;
    logic [15:0] wr_data;
    logic [15:0] regs [4];
    logic [15:0] rd_word;
    logic [7:0]  tx_byte;

    // Bus pins arrive from outside, so two flops before any use
    always_ff @(posedge clk) begin
        if (rst) begin
            scl_sy <= 2'h3;
            sda_sy <= 2'h3;
            scl_d  <= 1'b1;
            sda_d  <= 1'b1;
        end else if (ce) begin
            scl_sy <= {scl_sy[0], bus.scl};
            sda_sy <= {sda_sy[0], bus.sda};
            scl_d  <= scl_sy[1];
            sda_d  <= sda_sy[1];
        end
    end

    // Only sampled, never driven: no clock stretching possible
    assign scl_rise   = scl_sy[1] & ~scl_d;
    assign scl_fall   = ~scl_sy[1] & scl_d;
    assign start_seen = scl_sy[1] & scl_d & sda_d & ~sda_sy[1];
    assign stop_seen  = scl_sy[1] & scl_d & ~sda_d & sda_sy[1];
    assign rx_byte    = {shreg[6:0], sda_sy[1]};

    // Strap is caught after reset release, refreshed only between frames
    always_ff @(posedge clk) begin
        if (rst) begin
            sel_sy0 <= 2'h0;
            sel_sy1 <= 2'h0;
            my_addr <= BASE;
        end else if (ce) begin
            sel_sy0 <= addr_sel;
            sel_sy1 <= sel_sy0;
            if (st == ST_IDLE) begin
                my_addr <= BASE | {5'h00, sel_sy1};
            end
        end
    end

    // Register read mux and byte choice for the read phase
    assign rd_word = regs[ptr];
    assign tx_byte = (byte_idx == IDX_PTR) ? rd_word[15:8] : rd_word[7:0];

    // Protocol engine
    always_ff @(posedge clk) begin
        if (rst) begin
            st               <= ST_IDLE;
            bit_cnt          <= 4'h0;
            shreg            <= 8'h00;
            byte_idx         <= IDX_ADDR;
            rd_mode          <= 1'b0;
            ack_drv          <= 1'b0;
            ptr              <= PTR_CONV;
            hold_hi          <= 8'h00;
            wr_pulse         <= 1'b0;
            wr_index         <= PTR_CONV;
            wr_data          <= 16'h0000;
            bus.dev_sda_oe_n <= 1'b1;
            bus.dev_sda_out  <= 1'b0;
        end else if (ce) begin
            wr_pulse <= 1'b0;
            if (stop_seen) begin
                st               <= ST_IDLE;
                bus.dev_sda_oe_n <= 1'b1;
            end else if (start_seen) begin
                // Repeated start also restarts address decoding
                st               <= ST_RX;
                bit_cnt          <= 4'h0;
                byte_idx         <= IDX_ADDR;
                bus.dev_sda_oe_n <= 1'b1;
            end else begin
                case (st)
                    ST_IDLE: begin
                    end
                    ST_RX: begin
                        if (scl_rise) begin
                            shreg   <= rx_byte;
                            bit_cnt <= bit_cnt + 4'h1;
                            if (bit_cnt == BITS_PER_BYTE - 4'h1) begin
                                bit_cnt <= 4'h0;
                                ack_drv <= 1'b0;
                                st      <= ST_ACK;
                                if (byte_idx != IDX_OVER) begin
                                    byte_idx <= byte_idx + 3'h1;
                                end
                                if (byte_idx == IDX_ADDR) begin
                                    if (rx_byte[7:1] == my_addr) begin
                                        rd_mode <= rx_byte[0];
                                    end else begin
                                        st <= ST_SKIP;
                                    end
                                end else if (byte_idx == IDX_PTR) begin
                                    // Low two bits select the register
                                    ptr <= rx_byte[1:0];
                                end else if (byte_idx == IDX_HI) begin
                                    hold_hi <= rx_byte;
                                end else if (byte_idx == IDX_LO) begin
                                    wr_pulse <= 1'b1;
                                    wr_index <= ptr;
                                    wr_data  <= {hold_hi, rx_byte};
                                end
                            end
                        end
                    end
                    ST_ACK: begin
                        if (scl_fall) begin
                            if (!ack_drv) begin
                                ack_drv          <= 1'b1;
                                bus.dev_sda_oe_n <= 1'b0;
                            end else if (rd_mode) begin
                                st               <= ST_TX;
                                bit_cnt          <= 4'h1;
                                shreg            <= {tx_byte[6:0], 1'b0};
                                bus.dev_sda_oe_n <= tx_byte[7];
                            end else begin
                                st               <= ST_RX;
                                bus.dev_sda_oe_n <= 1'b1;
                            end
                        end
                    end
                    ST_TX: begin
                        if (scl_fall) begin
                            if (bit_cnt == BITS_PER_BYTE) begin
                                st               <= ST_MACK;
                                ack_drv          <= 1'b0;
                                bus.dev_sda_oe_n <= 1'b1;
                            end else begin
                                bus.dev_sda_oe_n <= shreg[7];
                                shreg            <= {shreg[6:0], 1'b0};
                                bit_cnt          <= bit_cnt + 4'h1;
                            end
                        end
                    end
                    ST_MACK: begin
                        // Only two bytes per read; more are not offered
                        if (scl_rise) begin
                            if (sda_sy[1] || byte_idx != IDX_PTR) begin
                                st <= ST_SKIP;
                            end else begin
                                ack_drv  <= 1'b1;
                                byte_idx <= IDX_HI;
                            end
                        end else if (scl_fall && ack_drv) begin
                            st               <= ST_TX;
                            bit_cnt          <= 4'h1;
                            shreg            <= {tx_byte[6:0], 1'b0};
                            bus.dev_sda_oe_n <= tx_byte[7];
                        end
                    end
                    ST_SKIP: begin
                        bus.dev_sda_oe_n <= 1'b1;
                    end
                    default: begin
                        st <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    // Register storage; conversion word is read-only from the bus
    always_ff @(posedge clk) begin
        if (rst) begin
            regs[PTR_CONV] <= 16'h0000;
            regs[PTR_CFG]  <= CFG_RESET;
            regs[PTR_LO]   <= LO_RESET;
            regs[PTR_HI]   <= HI_RESET;
        end else if (ce) begin
            regs[PTR_CONV] <= conv_word;
            if (wr_pulse && wr_index != PTR_CONV) begin
                regs[wr_index] <= wr_data;
            end
        end
    end

    assign cfg_word = regs[PTR_CFG];
    assign lo_word  = regs[PTR_LO];
    assign hi_word  = regs[PTR_HI];

endmodule
`default_nettype wire

/* adcp_host.sv */
// Controller end: issues write, point and read transactions
`timescale 1ns/1ps
`default_nettype none
module adcp_host #(
    parameter int QTR = adcp_pkg::QTR_CYCLES // cycles per quarter bit
) (
    input  wire logic               clk,       // system clock
    input  wire logic               rst,       // synchronous reset
    input  wire logic               ce,        // clock enable
    adcp_bus_if.host                bus,       // two-wire bus
    input  wire logic               cmd_valid, // command request
    output logic                    cmd_ready, // idle, accepts command
    input  wire adcp_pkg::adcp_op_type cmd_op, // operation
    input  wire logic [6:0]         cmd_addr,  // target address
    input  wire logic [7:0]         cmd_ptr,   // pointer byte
    input  wire logic [15:0]        cmd_data,  // write data
    output logic                    done,      // transaction over
    output logic                    nack,      // target refused a byte
    output logic      [15:0]        rd_data    // read result
);
    import adcp_pkg::*;

    typedef enum {
        H_IDLE,
        H_START,
        H_BIT,
        H_STOP
    } adcp_hstate_type;

    adcp_hstate_type st;
    adcp_op_type     op;
    logic [15:0] qcnt;
    logic        tick;
    logic [1:0]  ph;
    logic [3:0]  bit_n;
    logic [1:0]  byte_n;
    logic [1:0]  last_n;
    logic [6:0]  addr;
    logic [7:0]  ptr_b;
    logic [15:0] data;
    logic [7:0]  shreg;
    logic [1:0]  sda_sy;
    logic        is_rx;
    logic [7:0]  tx_byte;

    always_ff @(posedge clk) begin
        if (rst) begin
            sda_sy <= 2'h3;
        end else if (ce) begin
            sda_sy <= {sda_sy[0], bus.sda};
        end
    end

    // The controller alone makes the clock, from a divider
    always_ff @(posedge clk) begin
        if (rst) begin
            qcnt <= 16'h0000;
        end else if (ce) begin
            if (st == H_IDLE || tick) begin
                qcnt <= 16'h0000;
            end else begin
                qcnt <= qcnt + 16'h0001;
            end
        end
    end
    assign tick = (qcnt == 16'(QTR - 1));

    assign is_rx = (op == OP_READ) && (byte_n != 2'h0);
    always_comb begin
        case (byte_n)
            2'h0:    tx_byte = {addr, op == OP_READ};
            2'h1:    tx_byte = ptr_b;
            2'h2:    tx_byte = data[15:8];
            default: tx_byte = data[7:0];
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st                <= H_IDLE;
            op                <= OP_WRITE;
            ph                <= 2'h0;
            bit_n             <= 4'h0;
            byte_n            <= 2'h0;
            last_n            <= 2'h0;
            addr              <= 7'h00;
            ptr_b             <= 8'h00;
            data              <= 16'h0000;
            shreg             <= 8'h00;
            cmd_ready         <= 1'b1;
            done              <= 1'b0;
            nack              <= 1'b0;
            rd_data           <= 16'h0000;
            bus.host_scl_oe_n <= 1'b1;
            bus.host_sda_oe_n <= 1'b1;
            bus.host_scl_out  <= 1'b0;
            bus.host_sda_out  <= 1'b0;
        end else if (ce) begin
            done <= 1'b0;
            case (st)
                H_IDLE: begin
                    if (cmd_valid) begin
                        st        <= H_START;
                        cmd_ready <= 1'b0;
                        nack      <= 1'b0;
                        op        <= cmd_op;
                        addr      <= cmd_addr;
                        ptr_b     <= cmd_ptr;
                        data      <= cmd_data;
                        ph        <= 2'h0;
                        byte_n    <= 2'h0;
                        bit_n     <= 4'h0;
                        // Point-only write carries no data bytes
                        case (cmd_op)
                            OP_WRITE: last_n <= 2'h3;
                            OP_POINT: last_n <= 2'h1;
                            default:  last_n <= 2'h2;
                        endcase
                    end
                end
                H_START: begin
                    if (tick) begin
                        ph <= ph + 2'h1;
                        if (ph == 2'h1) begin
                            bus.host_sda_oe_n <= 1'b0;
                        end else if (ph == 2'h2) begin
                            bus.host_scl_oe_n <= 1'b0;
                            st    <= H_BIT;
                            ph    <= 2'h0;
                            shreg <= tx_byte;
                        end
                    end
                end
                H_BIT: begin
                    if (tick) begin
                        ph <= ph + 2'h1;
                        case (ph)
                            2'h0: begin
                                if (bit_n != BITS_PER_BYTE) begin
                                    bus.host_sda_oe_n <= is_rx | shreg[7];
                                end else begin
                                    // Last read byte gets a not-acknowledge
                                    bus.host_sda_oe_n <=
                                        !is_rx || byte_n == last_n;
                                end
                            end
                            2'h1: bus.host_scl_oe_n <= 1'b1;
                            2'h2: begin
                                if (bit_n != BITS_PER_BYTE) begin
                                    if (is_rx) begin
                                        shreg <= {shreg[6:0], sda_sy[1]};
                                    end else begin
                                        shreg <= {shreg[6:0], 1'b0};
                                    end
                                end else if (!is_rx && sda_sy[1]) begin
                                    nack <= 1'b1;
                                end
                            end
                            default: begin
                                bus.host_scl_oe_n <= 1'b0;
                                bit_n <= bit_n + 4'h1;
                                if (bit_n == BITS_PER_BYTE) begin
                                    bit_n <= 4'h0;
                                    if (is_rx) begin
                                        rd_data <= {rd_data[7:0], shreg};
                                    end
                                    if (nack || byte_n == last_n) begin
                                        st <= H_STOP;
                                    end else begin
                                        byte_n <= byte_n + 2'h1;
                                    end
                                end
                            end
                        endcase
                    end else if (ph == 2'h0 && bit_n == 4'h0) begin
                        // New byte is loaded while the clock is low
                        shreg <= tx_byte;
                    end
                end
                H_STOP: begin
                    if (tick) begin
                        ph <= ph + 2'h1;
                        case (ph)
                            2'h0: bus.host_sda_oe_n <= 1'b0;
                            2'h1: bus.host_scl_oe_n <= 1'b1;
                            2'h2: bus.host_sda_oe_n <= 1'b1;
                            default: begin
                                st        <= H_IDLE;
                                done      <= 1'b1;
                                cmd_ready <= 1'b1;
                            end
                        endcase
                    end
                end
                default: st <= H_IDLE;
            endcase
        end
    end

endmodule
`default_nettype wire

/* adcp_bus_asserts.sv */
// Checker for the two-wire bus between controller and target
`timescale 1ns/1ps
`default_nettype none
module adcp_bus_asserts
    import adcp_pkg::*;
(
    input wire logic clk,           // system clock
    input wire logic rst,           // synchronous reset
    input wire logic host_scl_out,  // controller clock drive
    input wire logic host_scl_oe_n, // controller clock enable
    input wire logic host_sda_out,  // controller data drive
    input wire logic host_sda_oe_n, // controller data enable
    input wire logic dev_sda_out,   // target data drive
    input wire logic dev_sda_oe_n,  // target data enable
    input wire logic scl,           // resolved clock
    input wire logic sda            // resolved data
);
    logic       scl_q;
    logic       sda_q;
    logic       in_frame;
    logic       hit;
    logic [3:0] bit_cnt;
    logic [2:0] byte_idx;
    logic [7:0] addr_sh;
    logic [3:0] idle_cnt;
    wire scl_rise = scl & ~scl_q;
    wire start_c  = scl & scl_q & sda_q & ~sda;
    wire stop_c   = scl & scl_q & ~sda_q & sda;
    wire ack_slot = scl_rise & in_frame & (bit_cnt == 4'h8);

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    always_ff @(posedge clk) begin
        scl_q <= scl;
        sda_q <= sda;
    end
    always_ff @(posedge clk) begin
        if (rst || stop_c) begin
            in_frame <= 1'b0;
        end else if (start_c) begin
            in_frame <= 1'b1;
        end
    end
    // Byte counter saturates so long writes cannot wrap into byte 0
    always_ff @(posedge clk) begin
        if (rst || start_c) begin
            bit_cnt  <= 4'h0;
            byte_idx <= 3'h0;
        end else if (scl_rise && in_frame) begin
            if (bit_cnt == 4'h8) begin
                bit_cnt  <= 4'h0;
                byte_idx <= byte_idx + ((byte_idx == 3'h7) ? 3'h0 : 3'h1);
            end else begin
                bit_cnt <= bit_cnt + 4'h1;
            end
        end
    end
    always_ff @(posedge clk) begin
        if (rst || start_c) begin
            hit <= 1'b0;
        end else if (scl_rise && in_frame && byte_idx == 3'h0) begin
            if (bit_cnt < 4'h8) begin
                addr_sh <= {addr_sh[6:0], sda};
            end else begin
                hit <= ~sda;
            end
        end
    end
    always_ff @(posedge clk) begin
        if (rst || in_frame) begin
            idle_cnt <= 4'h0;
        end else if (idle_cnt != 4'hF) begin
            idle_cnt <= idle_cnt + 4'h1;
        end
    end

    // Target only samples the clock, so each high phase must outlast
    // its two-flop synchroniser
    a_clk_high_min: assert property (scl_rise |-> scl [*5])
        else $error("clock high time too short to sample");
    a_dev_hold_high: assert property (
        scl && scl_q |-> $stable(dev_sda_oe_n))
        else $error("target data changed while clock high");
    a_start_by_host: assert property (
        start_c |-> !host_sda_oe_n && !host_sda_out)
        else $error("start not made by controller");
    a_stop_by_host: assert property (
        stop_c |-> dev_sda_oe_n && !$past(host_sda_oe_n))
        else $error("stop not made by controller");
    a_addr_quiet: assert property (
        in_frame && byte_idx == 3'h0 && bit_cnt < 4'h8 |-> dev_sda_oe_n)
        else $error("target drove data during address bits");
    a_ack_own_addr: assert property (
        ack_slot && byte_idx == 3'h0 && !sda
            |-> addr_sh[7:3] == BASE_ADDR[6:2])
        else $error("address acknowledged outside own range");
    a_write_data_ack: assert property (
        ack_slot && hit && !addr_sh[0] && byte_idx != 3'h0
            && byte_idx < 3'h4 |-> !sda)
        else $error("write byte not acknowledged");
    a_idle_release: assert property (
        idle_cnt == 4'hF |-> dev_sda_oe_n && !dev_sda_out)
        else $error("target holds data line between frames");

    c_start: cover property (start_c);
    c_read_acked: cover property (
        ack_slot && byte_idx == 3'h0 && !sda && addr_sh[0]);
    c_full_write: cover property (
        stop_c && hit && !addr_sh[0] && byte_idx == 3'h4);
endmodule
`default_nettype wire

/* tb.sv */
// Self-checking bench: controller and target joined over the bus
`timescale 1ns/1ps
`default_nettype none
module tb;
    import adcp_pkg::*;
    logic        clk, rst, cmd_valid, cmd_ready, done, nack, wr_pulse;
    adcp_op_type cmd_op;
    logic [6:0]  cmd_addr, dev;
    logic [7:0]  cmd_ptr;
    logic [15:0] cmd_data, rd_data, conv_word, cfg_word, lo_word, hi_word;
    logic [1:0]  addr_sel, wr_index;
    logic [1:0]  wq[$];
    int          fail_count, n_compared, seed, mptr, s, i, r;
    int          mreg[4];

    adcp_bus_if bus();
    adcp_host #(.QTR(8)) adcp_host_inst (.clk(clk), .rst(rst), .ce(1'b1),
        .bus(bus), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
        .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_ptr(cmd_ptr),
        .cmd_data(cmd_data), .done(done), .nack(nack), .rd_data(rd_data));
    adcp_device adcp_device_inst (.clk(clk), .rst(rst), .ce(1'b1),
        .bus(bus), .addr_sel(addr_sel), .conv_word(conv_word),
        .cfg_word(cfg_word), .lo_word(lo_word), .hi_word(hi_word),
        .wr_pulse(wr_pulse), .wr_index(wr_index));
    adcp_bus_asserts adcp_bus_asserts_inst (.clk(clk), .rst(rst),
        .host_scl_out(bus.host_scl_out), .host_scl_oe_n(bus.host_scl_oe_n),
        .host_sda_out(bus.host_sda_out), .host_sda_oe_n(bus.host_sda_oe_n),
        .dev_sda_out(bus.dev_sda_out), .dev_sda_oe_n(bus.dev_sda_oe_n),
        .scl(bus.scl), .sda(bus.sda));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // Pulse is one cycle wide, so the falling edge always catches it
    always @(negedge clk) if (wr_pulse === 1'b1) wq.push_back(wr_index);

    task chk_word(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task chk_bit(input logic got, input logic exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task summarize;
        $display("Compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task chk_regs;
        chk_word(cfg_word, 16'(mreg[1]));
        chk_word(lo_word, 16'(mreg[2]));
        chk_word(hi_word, 16'(mreg[3]));
    endtask

    task run(input adcp_op_type op, input logic [6:0] a,
             input logic [7:0] p, input logic [15:0] d);
        int   k;
        logic ok;
        ok = (a === (BASE_ADDR | {5'h0, addr_sel}));
        for (k = 0; cmd_ready !== 1'b1 && k < 100; k++) @(negedge clk);
        if (k == 100) begin
            fail_count++;
            summarize();
        end
        wq.delete();
        cmd_valid = 1'b1;
        cmd_op    = op;
        cmd_addr  = a;
        cmd_ptr   = p;
        cmd_data  = d;
        @(negedge clk);
        cmd_valid = 1'b0;
        for (k = 0; done !== 1'b1 && k < 5000; k++) @(negedge clk);
        if (k == 5000) begin
            fail_count++;
            summarize();
        end
        chk_bit(nack, !ok);
        chk_bit(cmd_ready, 1'b1);
        if (ok && op != OP_READ) mptr = int'(p[1:0]);
        if (ok && op == OP_WRITE && mptr != 0) mreg[mptr] = int'(d);
        chk_word(16'(wq.size()), 16'(ok && op == OP_WRITE));
        if (wq.size() == 1) chk_word({14'h0, wq[0]}, 16'(mptr));
        if (ok && op == OP_READ)
            chk_word(rd_data, mptr ? 16'(mreg[mptr]) : conv_word);
        chk_regs();
    endtask

    initial begin
        seed = 32'h90e44951;
        fail_count = 0;
        n_compared = 0;
        rst = 1'b1;
        cmd_valid = 1'b0;
        cmd_op = OP_WRITE;
        cmd_addr = 7'h00;
        cmd_ptr = 8'h00;
        cmd_data = 16'h0000;
        addr_sel = 2'h0;
        conv_word = 16'h0000;
        mreg = '{0, CFG_RESET, LO_RESET, HI_RESET};
        mptr = 0;
        repeat (12) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        chk_regs();
        for (s = 0; s < 4; s++) begin
            addr_sel = s[1:0];
            conv_word = 16'($random(seed));
            repeat (4) @(negedge clk);
            dev = BASE_ADDR | {5'h0, addr_sel};
            for (i = 0; i < 4; i++) begin
                r = $random(seed);
                run(OP_WRITE, dev, {r[5:0], i[1:0]}, r[23:8]);
            end
            for (i = 0; i < 4; i++) begin
                run(OP_POINT, dev, {6'h0, i[1:0]}, 16'h0000);
                run(OP_READ, dev, 8'h00, 16'h0000);
            end
            run(OP_WRITE, dev ^ 7'(1 + s % 2), 8'h01, r[15:0]);
            run(OP_READ, dev ^ 7'h10, 8'h00, 16'h0000);
            run(OP_READ, dev, 8'h00, 16'h0000);
        end
        summarize();
    end
endmodule
`default_nettype wire
